// ### hw/tsa_align_ctrl.sv
// sysref alignment control, error log and enable registers
// assumes sysref and gearbox flags synchronous to the link clock
//
// Contract
// - a sysref rising edge loads the counter with the offset field while single-detect or always-on is set.
// - the multiblock counter runs from 0 to E*16-1 on the link clock.
// - offsets above 255 cannot be applied; the field is eight bits.
// - an offset beyond the counter range is applied as zero.
// - default offset returns the counter to zero on the edge.
// - single-detect bit 2 resets to one and self-clears after capture.
// - single-detect realigns only on the first edge while set.
// - no end-of-multiblock marker before any sysref edge was sampled.
// - always-on bit 1 resets to zero, realigns on every edge.
// - always-on checks sysref period is a multiple of E*32.
// - reinit bit 0 resets pipeline and status, keeps sysref capture.
// - reinit bit self-clears on leaving reinit, resets to zero.
// - error log bits raise interrupt only when enabled at 0x64.
// - error bit 8 logs gearbox overflow, write one clears.
// - error bit 7 logs gearbox underflow, write one clears.
`timescale 1ns/1ps
module tsa_align_ctrl (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        write_in,
    input  wire logic        read_in,
    input  wire logic        sysref_in,
    input  wire logic        gearbox_overflow_in,
    input  wire logic        gearbox_underflow_in,
    output logic      [31:0] rdata_out,
    output logic      [11:0] lemc_count_out,
    output logic             end_multiblock_out,
    output logic             link_reinit_out,
    output logic             irq_out
);
    typedef enum logic [1:0] {
        TSA_IDLE,
        TSA_REINIT
    } tsa_state_e;

    tsa_state_e  state;
    logic [7:0]  offset;
    logic        single_edge_align_req;
    logic        always_on;
    logic        reinit_req;
    logic [8:0]  err_en;
    logic        period_err;
    logic        gearbox_underflow_flag;
    logic        gearbox_overflow_flag;
    logic        sysref_q;
    logic        sysref_rise;
    logic        sysref_seen;
    logic        align_load;
    logic [11:0] count;
    logic        wrap;
    logic [11:0] period_cnt;
    logic        period_armed;
    logic [8:0]  err_vec;
    logic        wr_ctrl;
    logic        wr_log;
    logic        wr_en;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    assign wr_ctrl     = write_in && hit(addr_in, tsa_pkg::ADDR_SYSREF_CTRL);
    assign wr_log      = write_in && hit(addr_in, tsa_pkg::ADDR_ERROR_LOG);
    assign wr_en       = write_in && hit(addr_in, tsa_pkg::ADDR_ERROR_EN);
    assign sysref_rise = sysref_in && !sysref_q;
    assign align_load  = sysref_rise && (single_edge_align_req || always_on);

    always_comb begin
        err_vec = 9'h000;
        err_vec[tsa_pkg::ERR_PERIOD_BIT] = period_err;
        err_vec[tsa_pkg::ERR_UNDER_BIT]  = gearbox_underflow_flag;
        err_vec[tsa_pkg::ERR_OVER_BIT]   = gearbox_overflow_flag;
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sysref_q <= 1'b0;
        end else begin
            sysref_q <= sysref_in;
        end
    end

    // sysref capture survives reinit on purpose
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sysref_seen <= 1'b0;
        end else if (align_load) begin
            sysref_seen <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            offset <= tsa_pkg::OFFSET_RESET;
        end else if (wr_ctrl) begin
            offset <= wdata_in[tsa_pkg::OFFSET_LSB +: 8];
        end
    end

    // a write-one beats the hardware clear in the same cycle
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            single_edge_align_req <= tsa_pkg::SINGLE_RESET;
        end else if (wr_ctrl && wdata_in[tsa_pkg::CTRL_SINGLE_BIT]) begin
            single_edge_align_req <= 1'b1;
        end else if (sysref_rise && single_edge_align_req) begin
            single_edge_align_req <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            always_on <= tsa_pkg::ALWAYS_RESET;
        end else if (wr_ctrl) begin
            always_on <= wdata_in[tsa_pkg::CTRL_ALWAYS_BIT];
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reinit_req <= tsa_pkg::REINIT_RESET;
        end else if (wr_ctrl && wdata_in[tsa_pkg::CTRL_REINIT_BIT]) begin
            reinit_req <= 1'b1;
        end else if (state == TSA_REINIT) begin
            reinit_req <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= TSA_IDLE;
        end else begin
            case (state)
                TSA_IDLE: begin
                    if (reinit_req) begin
                        state <= TSA_REINIT;
                    end
                end
                TSA_REINIT: begin
                    state <= TSA_IDLE;
                end
                default: begin
                    state <= TSA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link_reinit_out <= 1'b0;
        end else begin
            link_reinit_out <= (state == TSA_IDLE) && reinit_req;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            err_en <= tsa_pkg::ERR_EN_RESET;
        end else if (wr_en) begin
            err_en <= wdata_in[8:0];
        end
    end

    // period counter spans edges; any edge off an E*32 multiple is an error
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            period_cnt   <= 12'h000;
            period_armed <= 1'b0;
        end else if (!always_on) begin
            period_cnt   <= 12'h000;
            period_armed <= 1'b0;
        end else if (sysref_rise) begin
            period_cnt   <= 12'h001;
            period_armed <= 1'b1;
        end else if (period_cnt >= tsa_pkg::SYSREF_PERIOD - 12'h001) begin
            period_cnt <= 12'h000;
        end else begin
            period_cnt <= period_cnt + 12'h001;
        end
    end

    // a new error wins over a write-one clear in the same cycle
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            period_err <= 1'b0;
        end else if (always_on && sysref_rise && period_armed &&
                     period_cnt != 12'h000) begin
            period_err <= 1'b1;
        end else if (link_reinit_out ||
                     (wr_log && wdata_in[tsa_pkg::ERR_PERIOD_BIT])) begin
            period_err <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gearbox_underflow_flag <= 1'b0;
        end else if (gearbox_underflow_in) begin
            gearbox_underflow_flag <= 1'b1;
        end else if (link_reinit_out ||
                     (wr_log && wdata_in[tsa_pkg::ERR_UNDER_BIT])) begin
            gearbox_underflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gearbox_overflow_flag <= 1'b0;
        end else if (gearbox_overflow_in) begin
            gearbox_overflow_flag <= 1'b1;
        end else if (link_reinit_out ||
                     (wr_log && wdata_in[tsa_pkg::ERR_OVER_BIT])) begin
            gearbox_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(err_vec & err_en);
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (read_in) begin
            case (addr_in)
                tsa_pkg::ADDR_SYSREF_CTRL: begin
                    rdata_out <= {16'h0000, offset, 5'h00,
                                  single_edge_align_req, always_on,
                                  reinit_req};
                end
                tsa_pkg::ADDR_ERROR_LOG: begin
                    rdata_out <= {23'h000000, err_vec};
                end
                tsa_pkg::ADDR_ERROR_EN: begin
                    rdata_out <= {23'h000000, err_en};
                end
                default: begin
                    rdata_out <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    tsa_lemc_counter u_counter (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .load_in    (align_load),
        .offset_in  (offset),
        .count_out  (count),
        .wrap_out   (wrap)
    );

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lemc_count_out     <= 12'h000;
            end_multiblock_out <= 1'b0;
        end else begin
            lemc_count_out     <= count;
            end_multiblock_out <= wrap && sysref_seen;
        end
    end
endmodule : tsa_align_ctrl

// ### hw/tsa_pkg.sv
// constants for the sysref multiblock alignment controller
// assumes a plain register port and one link clock
package tsa_pkg;
    localparam logic [7:0]  ADDR_SYSREF_CTRL = 8'h54;
    localparam logic [7:0]  ADDR_ERROR_LOG   = 8'h60;
    localparam logic [7:0]  ADDR_ERROR_EN    = 8'h64;
    localparam int          CTRL_REINIT_BIT  = 0;
    localparam int          CTRL_ALWAYS_BIT  = 1;
    localparam int          CTRL_SINGLE_BIT  = 2;
    localparam int          OFFSET_LSB       = 8;
    localparam int          ERR_PERIOD_BIT   = 0;
    localparam int          ERR_UNDER_BIT    = 7;
    localparam int          ERR_OVER_BIT     = 8;
    localparam logic [7:0]  OFFSET_RESET     = 8'h00;
    localparam logic        SINGLE_RESET     = 1'h1;
    localparam logic        ALWAYS_RESET     = 1'h0;
    localparam logic        REINIT_RESET     = 1'h0;
    localparam logic [8:0]  ERR_EN_RESET     = 9'h181;
    localparam int          E_MULTI          = 1;
    localparam int          LEMC_TOP_INT     = E_MULTI * 16 - 1;
    localparam logic [11:0] LEMC_TOP         = 12'(LEMC_TOP_INT);
    localparam logic [11:0] SYSREF_PERIOD    = 12'(E_MULTI * 32);
    localparam logic [11:0] OFFSET_MAX       = 12'h0FF;
endpackage : tsa_pkg

// ### hw/tsa_lemc_counter.sv
// local extended multiblock counter with sysref alignment load
// assumes sysref edge pulse already formed in the link clock domain
`timescale 1ns/1ps
module tsa_lemc_counter (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    input  wire logic        load_in,
    input  wire logic [7:0]  offset_in,
    output logic      [11:0] count_out,
    output logic             wrap_out
);
    logic [11:0] applied;

    // out-of-range offset falls back to zero; no offset beyond 255 exists
    always_comb begin
        applied = {4'h0, offset_in};
        if (tsa_pkg::LEMC_TOP < tsa_pkg::OFFSET_MAX &&
            applied > tsa_pkg::LEMC_TOP) begin
            applied = 12'h000;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_out <= 12'h000;
        end else if (load_in) begin
            count_out <= applied;
        end else if (count_out >= tsa_pkg::LEMC_TOP) begin
            count_out <= 12'h000;
        end else begin
            count_out <= count_out + 12'h001;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wrap_out <= 1'b0;
        end else begin
            wrap_out <= !load_in && count_out >= tsa_pkg::LEMC_TOP;
        end
    end
endmodule : tsa_lemc_counter

// ### verification/tsa_align_props.sv
// port assertions for the sysref alignment controller
// assumes one link clock and an asynchronous active low reset
`timescale 1ns/1ps
module tsa_align_props (
    input wire logic        clock_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        write_in,
    input wire logic        read_in,
    input wire logic        sysref_in,
    input wire logic        gearbox_overflow_in,
    input wire logic        gearbox_underflow_in,
    input wire logic [31:0] rdata_out,
    input wire logic [11:0] lemc_count_out,
    input wire logic        end_multiblock_out,
    input wire logic        link_reinit_out,
    input wire logic        irq_out
);
    logic edge_seen;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // any sysref high since reset; looser than a capture, never stricter
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) edge_seen <= 1'b0;
        else if (sysref_in) edge_seen <= 1'b1;
    end
    cnt_range_a: assert property (lemc_count_out <= tsa_pkg::LEMC_TOP)
        else $error("counter beyond multiblock range");
    cnt_step_a: assert property ($past(reset_n_in, 2) && !$past(sysref_in, 2)
        && !link_reinit_out && !$past(link_reinit_out)
        |-> lemc_count_out == (($past(lemc_count_out) == tsa_pkg::LEMC_TOP)
        ? 12'h000 : $past(lemc_count_out) + 12'h001))
        else $error("counter did not step or wrap");
    marker_gate_a: assert property (end_multiblock_out |-> edge_seen)
        else $error("end marker before any sysref");
    reinit_pulse_a: assert property (link_reinit_out |=> !link_reinit_out)
        else $error("reinit pulse longer than one cycle");
    reinit_req_a: assert property (write_in
        && addr_in == tsa_pkg::ADDR_SYSREF_CTRL && wdata_in[0]
        |-> ##[1:2] link_reinit_out) else $error("reinit not entered");
    irq_cause_a: assert property ($rose(irq_out) |-> $past(write_in, 2)
        || $past(gearbox_overflow_in, 2) || $past(gearbox_underflow_in, 2)
        || $past(sysref_in, 2) || $past(sysref_in, 3))
        else $error("interrupt rose without cause");
    irq_drop_a: assert property ($fell(irq_out) |-> $past(write_in, 2)
        || $past(write_in, 3) || $past(write_in, 4))
        else $error("interrupt fell without a write");
    en_width_a: assert property (read_in
        && addr_in == tsa_pkg::ADDR_ERROR_EN |=> rdata_out[31:9] == 23'h0)
        else $error("enable register reserved bits set");
endmodule : tsa_align_props
bind tsa_align_ctrl tsa_align_props i_tsa_align_props (.clock_in,
    .reset_n_in, .addr_in, .wdata_in, .write_in, .read_in, .sysref_in,
    .gearbox_overflow_in, .gearbox_underflow_in, .rdata_out,
    .lemc_count_out, .end_multiblock_out, .link_reinit_out, .irq_out);

// ### verification/tsa_sysref_src.sv
// sysref source standing for the converter side of the link
// assumes the bench sets the period and starts and stops the train
`timescale 1ns/1ps
module tsa_sysref_src (
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    input  wire logic       run_in,
    input  wire logic [7:0] gap_in,
    output logic            sysref_out
);
    logic [7:0] phase;
    // edges sit on multiples of the gap, so a good period never drifts
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase      <= 8'h00;
            sysref_out <= 1'b0;
        end else begin
            phase      <= (!run_in || phase == gap_in - 8'h01) ? 8'h00
                          : phase + 8'h01;
            sysref_out <= run_in && phase < 8'h04;
        end
    end
endmodule : tsa_sysref_src

// ### verification/tb.sv
// self-checking bench for the sysref alignment controller
// assumes the sysref source model and the props bind are compiled
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] A_CTRL = tsa_pkg::ADDR_SYSREF_CTRL;
    localparam logic [7:0] A_LOG  = tsa_pkg::ADDR_ERROR_LOG;
    localparam logic [7:0] A_EN   = tsa_pkg::ADDR_ERROR_EN;
    logic        clock_in, reset_n_in, write_in, read_in, cmp_on;
    logic        run, over, under, sysref, end_mb, reinit, irq, sr_prev;
    logic [7:0]  addr_in, gap;
    logic [31:0] wdata_in, rdata;
    logic [11:0] lemc, exp_lemc;
    int          err_total, checks, m_cnt, m_off, m_log, m_en, off, ends;
    int          reinits, m_single, m_always;
    tsa_align_ctrl i_tsa_align_ctrl (.clock_in, .reset_n_in, .addr_in,
        .wdata_in, .write_in, .read_in, .sysref_in(sysref),
        .gearbox_overflow_in(over), .gearbox_underflow_in(under),
        .rdata_out(rdata), .lemc_count_out(lemc),
        .end_multiblock_out(end_mb), .link_reinit_out(reinit), .irq_out(irq));
    tsa_sysref_src i_tsa_sysref_src (.clock_in, .reset_n_in, .run_in(run),
        .gap_in(gap), .sysref_out(sysref));
    task automatic check(input logic [31:0] got, input int exp);
        checks++;
        if (got !== 32'(exp)) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input int d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= 32'(d);
        write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
        if (a == A_CTRL) begin
            m_off    = d[15:8];
            m_always = d[1];
            if (d[2]) m_single = 1;
        end
        if (a == A_LOG) m_log = m_log & ~d;
        if (a == A_EN) m_en = d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input int exp);
        @(posedge clock_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        @(negedge clock_in);
        check(rdata, exp);
    endtask : rd
    task automatic pulse();
        @(posedge clock_in);
        run <= 1'b1;
        repeat (70) @(posedge clock_in);
        run <= 1'b0;
    endtask : pulse
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // reference counter; one cycle behind like the design's output
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            m_cnt    = 0;
            m_off    = int'(tsa_pkg::OFFSET_RESET);
            m_log    = 0;
            m_always = int'(tsa_pkg::ALWAYS_RESET);
            m_single = int'(tsa_pkg::SINGLE_RESET);
            m_en     = int'(tsa_pkg::ERR_EN_RESET);
            exp_lemc <= 12'h000;
        end else begin
            exp_lemc <= 12'(m_cnt);
            if (sysref && !sr_prev && (m_single || m_always)) begin
                m_cnt    = (m_off > tsa_pkg::LEMC_TOP_INT) ? 0 : m_off;
                m_single = 0;
            end else m_cnt = (m_cnt + 1) % (tsa_pkg::LEMC_TOP_INT + 1);
        end
        sr_prev = sysref;
    end
    always @(negedge clock_in) begin
        if (cmp_on) check(32'(lemc), int'(exp_lemc));
        if (end_mb === 1'b1) ends++;
        if (reinit === 1'b1) reinits++;
    end
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    initial begin
        repeat (30000) @(posedge clock_in);
        err_total++;
        complete_run();
    end
    initial begin
        {reset_n_in, write_in, read_in, run, over, under, cmp_on} = '0;
        {addr_in, wdata_in, gap} = {8'h00, 32'h0, 8'd32};
        {err_total, checks, ends, reinits} = '0;
        void'($urandom(19717));
        repeat (6) @(posedge clock_in);
        reset_n_in <= 1'b1;
        cmp_on     <= 1'b1;
        rd(A_CTRL, 'h4);
        rd(A_LOG, 0);
        rd(A_EN, 'h181);
        rd(8'h58, 0);
        repeat (40) @(posedge clock_in);
        check(32'(ends), 0);
        for (int i = 0; i < 6; i++) begin
            off = (i == 0) ? 0 : (i == 1) ? 255 : $urandom % 32;
            wr(A_CTRL, off << 8 | 'h4);
            pulse();
            rd(A_CTRL, off << 8);
        end
        check(32'(ends > 0), 1);
        wr(A_CTRL, 'h302);
        run <= 1'b1;
        repeat (100) @(posedge clock_in);
        wr(A_LOG, 1);
        repeat (100) @(posedge clock_in);
        rd(A_LOG, 0);
        gap <= 8'd40;
        repeat (90) @(posedge clock_in);
        run <= 1'b0;
        m_log = 1;
        rd(A_LOG, 1);
        check(32'(irq), 1);
        wr(A_CTRL, 0);
        wr(A_LOG, 1);
        rd(A_LOG, 0);
        for (int b = 7; b <= 8; b++) begin
            // gearbox pulses launch on a rising edge like every other input
            @(posedge clock_in);
            over  <= (b == 8);
            under <= (b == 7);
            @(posedge clock_in);
            {over, under} <= 2'b00;
            m_log = 1 << b;
            rd(A_LOG, m_log);
            check(32'(irq), 1);
            wr(A_EN, 'h181 & ~m_log);
            rd(A_EN, m_en);
            repeat (2) @(negedge clock_in);
            check(32'(irq), 0);
            wr(A_LOG, m_log);
            rd(A_LOG, 0);
            wr(A_EN, 'h181);
        end
        over <= 1'b1;
        @(posedge clock_in);
        over <= 1'b0;
        rd(A_LOG, 'h100);
        wr(A_CTRL, 1);
        repeat (4) @(negedge clock_in);
        check(32'(reinits), 1);
        rd(A_CTRL, 0);
        rd(A_LOG, 0);
        // reinit keeps the sysref capture, so end markers carry on
        off = ends;
        repeat (20) @(posedge clock_in);
        check(32'(ends > off), 1);
        wr(A_CTRL, 'h4);
        pulse();
        rd(A_CTRL, 0);
        repeat (20) @(posedge clock_in);
        complete_run();
    end
endmodule : tb
